//--- hdl/board_io_glue_decoder.v
// Board I/O glue: select decode, digital I/O mapping, serial timing, header signals
// Functional notes
// - Three active-low group selects with four low address bits reach 48 registers.
// - Groups decode I/O bases 0x150, 0x160 and 0x170.
// - At most one group select is asserted at any time.
// - Inputs 0..11 are software channels 1..12, channel n is line n-1.
// - An input channel reads 1 when its line is high, else 0.
// - Sixteen outputs: eight parallel lines and eight individually selectable lines.
// - Six individual outputs plus driver enable feed seven high-current channels in order.
// - Disabling the RS-485 driver also disables all high-current outputs.
// - Driver enable line doubles as plain output and seventh high-current channel.
// - Without EEPROM the EEPROM clock line is a general-purpose output.
// - Serial ports run 300 to 57600 bps, two RS-232 or RS-232 plus RS-485.
// - Two active-low DMA requests reach processor DMA channels zero and one.
// - First interrupt reserved, second expansion bus, third free for the user.
// - Active-low header reset forces a full board hardware reset.
// - Unused expansion bus data lines serve as general-purpose I/O.
// - Writing 0 drives an output low or off, 1 drives it high or on.
`timescale 1ns/1ps
`default_nettype none
`include "board_io_regs.vh"

module board_io_glue_decoder #(
   parameter ADDR_W = 16,
   parameter IN_W = 12
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output wire wb_ack_o,
   // Processor I/O bus
   input wire [ADDR_W-1:0] ioAddr,
   input wire ioRd_n,
   input wire ioWr_n,
   input wire [7:0] ioWrData,
   output reg [7:0] ioRdData,
   // Group selects
   output wire group_one_select_n,
   output wire group_two_select_n,
   output wire group_three_select_n,
   // Digital inputs and outputs
   input wire [IN_W-1:0] digital_input_lines,
   output reg [7:0] parallel_output_lines,
   output reg [5:0] individual_output_lines,
   output reg rs485_driver_enable,
   output reg eepromClock,
   input wire eepromClockFromCore,
   output reg [6:0] high_current_channels,
   output reg highCurrentDriverEnable,
   // Serial timing
   output reg baudTickZero,
   output reg baudTickOne,
   output reg serialRs485Mode,
   // Expansion bus data lines
   input wire [7:0] expDataIn,
   output reg [7:0] expDataOut,
   output reg [7:0] expDataOe,
   // Header DMA, interrupt and reset
   input wire dma_request_zero_n,
   input wire dma_request_one_n,
   output reg cpuDmaReqZero_n,
   output reg cpuDmaReqOne_n,
   input wire expansion_bus_interrupt_n,
   input wire user_interrupt_n,
   output wire reserved_interrupt_n,
   output reg cpuIntOne_n,
   output reg cpuIntTwo_n,
   input wire headerReset_n,
   output wire boardReset_n
);

   // ----------------------------------------------------------------
   // Group select decode
   // ----------------------------------------------------------------
   wire ioStrobe;
   assign ioStrobe = ~ioRd_n | ~ioWr_n;

   // Disjoint bases keep the three selects mutually exclusive
   group_select_decode #(.ADDR_W(ADDR_W), .BASE(`GROUP_ONE_BASE)) uGroupOne (
      .ioAddr(ioAddr),
      .ioStrobe(ioStrobe),
      .select_n(group_one_select_n)
   );
   group_select_decode #(.ADDR_W(ADDR_W), .BASE(`GROUP_TWO_BASE)) uGroupTwo (
      .ioAddr(ioAddr),
      .ioStrobe(ioStrobe),
      .select_n(group_two_select_n)
   );
   group_select_decode #(.ADDR_W(ADDR_W), .BASE(`GROUP_THREE_BASE)) uGroupThree (
      .ioAddr(ioAddr),
      .ioStrobe(ioStrobe),
      .select_n(group_three_select_n)
   );

   wire anyGroup;
   assign anyGroup = ~(group_one_select_n & group_two_select_n & group_three_select_n);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [7:0] pout_ff;
   reg [7:0] iout_ff;
   reg [7:0] cfg_ff;
   reg [7:0] xout_ff;
   reg [7:0] xoe_ff;
   reg [8:0] serial_ff;
   reg [3:0] chanSel_ff;
   reg ack_ff;
   reg [15:0] selSeen_ff;

   wire wbReq;
   wire wbWr;
   wire [5:0] regIdx;
   assign wbReq = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wbWr = wbReq & wb_we_i & wb_sel_i[0];
   assign regIdx = wb_adr_i[7:2];
   assign wb_ack_o = ack_ff;

   // Channel write: value in bit 8, channel number 1..16 in low bits
   wire [4:0] chNum;
   wire chVal;
   assign chNum = wb_dat_i[4:0];
   assign chVal = wb_dat_i[`CH_VALUE_BIT];

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
         pout_ff <= `POUT_RESET;
         iout_ff <= `IOUT_RESET;
         cfg_ff <= `CFG_RESET;
         xout_ff <= 8'h00;
         xoe_ff <= 8'h00;
         serial_ff <= `SERIAL_RESET;
         chanSel_ff <= 4'h0;
      end else begin
         ack_ff <= wbReq;
         if (wbWr) begin
            case (regIdx)
               `REG_POUT: pout_ff <= wb_dat_i[7:0];
               `REG_IOUT: iout_ff <= wb_dat_i[7:0];
               `REG_CFG: cfg_ff <= wb_dat_i[7:0];
               `REG_XOUT: xout_ff <= wb_dat_i[7:0];
               `REG_XOE: xoe_ff <= wb_dat_i[7:0];
               `REG_SERIAL: serial_ff <= wb_dat_i[8:0];
               `REG_CHANNEL: begin
                  // Input channel n reads line n-1
                  chanSel_ff <= wb_dat_i[3:0] - 4'h1;
                  if (chNum >= 5'h01 && chNum <= 5'h08) begin
                     pout_ff[chNum[2:0] - 3'h1] <= chVal;
                  end else if (chNum >= 5'h09 && chNum <= 5'h10) begin
                     iout_ff[chNum[2:0] - 3'h1] <= chVal;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------
   wire inChanBit;
   assign inChanBit = (chanSel_ff < IN_W) ? digital_input_lines[chanSel_ff] : 1'b0;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= 32'h00000000;
      end else if (wbReq) begin
         case (regIdx)
            `REG_DIN: wb_dat_o <= {{(32-IN_W){1'b0}}, digital_input_lines};
            `REG_POUT: wb_dat_o <= {24'h000000, pout_ff};
            `REG_IOUT: wb_dat_o <= {24'h000000, iout_ff};
            `REG_CHANNEL: wb_dat_o <= {23'h000000, inChanBit, 4'h0, chanSel_ff};
            `REG_CFG: wb_dat_o <= {24'h000000, cfg_ff};
            `REG_XOUT: wb_dat_o <= {24'h000000, xout_ff};
            `REG_XOE: wb_dat_o <= {24'h000000, xoe_ff};
            `REG_STATUS: wb_dat_o <= {selSeen_ff, expDataIn, 3'h0, user_interrupt_n,
                                      expansion_bus_interrupt_n, headerReset_n,
                                      dma_request_one_n, dma_request_zero_n};
            `REG_SERIAL: wb_dat_o <= {23'h000000, serial_ff};
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end

   // Sticky record of which select has fired; cleared by a write to status
   // Set wins over clear so no strobe is missed
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         selSeen_ff <= 16'h0000;
      end else begin
         selSeen_ff <= ((wbWr && regIdx == `REG_STATUS) ? 16'h0000 : selSeen_ff)
                       | {13'h0000, ~group_three_select_n, ~group_two_select_n,
                          ~group_one_select_n};
      end
   end

   // ----------------------------------------------------------------
   // Output mapping
   // ----------------------------------------------------------------
   wire rs485En;
   assign rs485En = iout_ff[`IOUT_RS485_BIT];

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         parallel_output_lines <= 8'h00;
         individual_output_lines <= 6'h00;
         rs485_driver_enable <= 1'b0;
         high_current_channels <= 7'h00;
         highCurrentDriverEnable <= 1'b0;
         eepromClock <= 1'b0;
      end else begin
         parallel_output_lines <= pout_ff;
         individual_output_lines <= iout_ff[5:0];
         // Plain output bit, no mode switch needed
         rs485_driver_enable <= rs485En;
         // Shared enable: driver off forces every channel off
         high_current_channels <= {rs485En, iout_ff[5:0]} & {7{rs485En}};
         highCurrentDriverEnable <= rs485En;
         eepromClock <= cfg_ff[`CFG_SCL_GPO_BIT] ? iout_ff[`IOUT_SCL_BIT]
                                                 : eepromClockFromCore;
      end
   end

   // ----------------------------------------------------------------
   // Expansion bus data lines
   // ----------------------------------------------------------------
   wire xGpio;
   assign xGpio = cfg_ff[`CFG_XBUS_GPIO_BIT];

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         expDataOut <= 8'h00;
         expDataOe <= 8'h00;
         ioRdData <= 8'h00;
      end else begin
         if (xGpio) begin
            expDataOut <= xout_ff;
            expDataOe <= xoe_ff;
         end else begin
            // Registered, so write data reaches the lines one cycle late
            expDataOut <= ioWrData;
            expDataOe <= {8{~ioWr_n & anyGroup}};
         end
         ioRdData <= expDataIn;
      end
   end

   // ----------------------------------------------------------------
   // Serial baud enables
   // ----------------------------------------------------------------
   function [15:0] baudDiv;
      input [3:0] sel;
      reg [31:0] rate;
      begin
         case (sel)
            4'h0: rate = `BAUD_MIN;
            4'h1: rate = 600;
            4'h2: rate = 1200;
            4'h3: rate = 2400;
            4'h4: rate = 4800;
            4'h5: rate = 9600;
            4'h6: rate = 19200;
            4'h7: rate = 38400;
            default: rate = `BAUD_MAX;
         endcase
         rate = `CLK_HZ / (`BAUD_OVERSAMPLE * rate) - 1;
         baudDiv = rate[15:0];
      end
   endfunction

   reg [15:0] baudCnt0_ff;
   reg [15:0] baudCnt1_ff;
   wire [15:0] div0;
   wire [15:0] div1;
   assign div0 = baudDiv(serial_ff[3:0]);
   assign div1 = baudDiv(serial_ff[7:4]);

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         baudCnt0_ff <= 16'h0000;
         baudCnt1_ff <= 16'h0000;
         baudTickZero <= 1'b0;
         baudTickOne <= 1'b0;
         serialRs485Mode <= 1'b0;
      end else begin
         baudTickZero <= (baudCnt0_ff >= div0);
         baudTickOne <= (baudCnt1_ff >= div1);
         baudCnt0_ff <= (baudCnt0_ff >= div0) ? 16'h0000 : baudCnt0_ff + 16'h0001;
         baudCnt1_ff <= (baudCnt1_ff >= div1) ? 16'h0000 : baudCnt1_ff + 16'h0001;
         serialRs485Mode <= serial_ff[`SER_MODE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Header DMA, interrupt and reset routing
   // ----------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cpuDmaReqZero_n <= 1'b1;
         cpuDmaReqOne_n <= 1'b1;
         cpuIntOne_n <= 1'b1;
         cpuIntTwo_n <= 1'b1;
      end else begin
         cpuDmaReqZero_n <= dma_request_zero_n;
         cpuDmaReqOne_n <= dma_request_one_n;
         cpuIntOne_n <= expansion_bus_interrupt_n;
         cpuIntTwo_n <= user_interrupt_n;
      end
   end

   // Kept idle, never driven active
   assign reserved_interrupt_n = 1'b1;
   // Combinational so a pushbutton resets even without a clock
   assign boardReset_n = rst_n & headerReset_n;

endmodule // board_io_glue_decoder

`default_nettype wire

//--- hdl/board_io_regs.vh
// Register offsets, fields, reset values and timing counts for the board I/O glue
`ifndef BOARD_IO_REGS_VH
`define BOARD_IO_REGS_VH

// ----------------------------------------------------------------
// Register word indices (byte offset is index times four)
// ----------------------------------------------------------------
`define REG_DIN      6'h00
`define REG_POUT     6'h01
`define REG_IOUT     6'h02
`define REG_CHANNEL  6'h03
`define REG_CFG      6'h04
`define REG_XOUT     6'h05
`define REG_XOE      6'h06
`define REG_STATUS   6'h07
`define REG_SERIAL   6'h08

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define IOUT_RS485_BIT 6
`define IOUT_SCL_BIT 7
`define CH_VALUE_BIT 8
`define CFG_SCL_GPO_BIT 0
`define CFG_XBUS_GPIO_BIT 1
`define SER_MODE_BIT 8

// ----------------------------------------------------------------
// Group base addresses
// ----------------------------------------------------------------
`define GROUP_ONE_BASE 16'h0150
`define GROUP_TWO_BASE 16'h0160
`define GROUP_THREE_BASE 16'h0170

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define POUT_RESET 8'h00
`define IOUT_RESET 8'h00
`define CFG_RESET 8'h00
`define SERIAL_RESET 9'h005

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 100000000
`define BAUD_OVERSAMPLE 16
`define BAUD_MIN 300
`define BAUD_MAX 57600

`endif

//--- hdl/group_select_decode.v
// Active-low group select strobe decoder for one block of sixteen I/O registers
`timescale 1ns/1ps
`default_nettype none

module group_select_decode #(
   parameter ADDR_W = 16,
   parameter [15:0] BASE = 16'h0150
) (
   // Processor I/O bus
   input wire [ADDR_W-1:0] ioAddr,
   input wire ioStrobe,
   // Strobe out
   output wire select_n
);

   // Low nibble picks the register, upper bits pick the group
   assign select_n = ~(ioStrobe && (ioAddr[ADDR_W-1:4] == BASE[ADDR_W-1:4]));

endmodule // group_select_decode

`default_nettype wire

//--- dv/board_io_glue_decoder_assertions.sv
// Port-level assertions for the board I/O glue
`timescale 1ns/1ps
`default_nettype none
module board_io_glue_decoder_assertions #(
   parameter ADDR_W = 16
) (
   // Clock, reset, buses
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [ADDR_W-1:0] ioAddr,
   input wire logic ioRd_n,
   input wire logic ioWr_n,
   // Selects and outputs
   input wire logic group_one_select_n,
   input wire logic group_two_select_n,
   input wire logic group_three_select_n,
   input wire logic [5:0] individual_output_lines,
   input wire logic rs485_driver_enable,
   input wire logic [6:0] high_current_channels,
   // Header lines
   input wire logic dma_request_zero_n,
   input wire logic cpuDmaReqZero_n,
   input wire logic expansion_bus_interrupt_n,
   input wire logic cpuIntOne_n,
   input wire logic reserved_interrupt_n,
   input wire logic headerReset_n,
   input wire logic boardReset_n
);
   wire ioAct = !ioRd_n || !ioWr_n;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_sel_exclusive: assert property (
      $countones({group_one_select_n, group_two_select_n, group_three_select_n}) >= 2)
      else $error("two group selects low");
   a_group_one: assert property (
      group_one_select_n == !(ioAct && ioAddr[15:4] == 12'h015))
      else $error("group one select wrong");
   a_group_two: assert property (
      group_two_select_n == !(ioAct && ioAddr[15:4] == 12'h016))
      else $error("group two select wrong");
   a_group_three: assert property (
      group_three_select_n == !(ioAct && ioAddr[15:4] == 12'h017))
      else $error("group three select wrong");
   a_ack_pulse: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged");
   a_hc_coupled: assert property (
      high_current_channels == ({7{rs485_driver_enable}} & {rs485_driver_enable, individual_output_lines}))
      else $error("high current channels wrong");
   a_dma_forward: assert property (
      $past(rst_n) |-> cpuDmaReqZero_n == $past(dma_request_zero_n))
      else $error("dma request not forwarded");
   a_irq_forward: assert property (
      $past(rst_n) |-> cpuIntOne_n == $past(expansion_bus_interrupt_n) && reserved_interrupt_n)
      else $error("interrupt routing wrong");
   a_board_reset: assert property (
      boardReset_n == headerReset_n)
      else $error("board reset not following header");
endmodule // board_io_glue_decoder_assertions
bind board_io_glue_decoder board_io_glue_decoder_assertions #(.ADDR_W(ADDR_W)) chk (
   .clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ioAddr, .ioRd_n, .ioWr_n,
   .group_one_select_n, .group_two_select_n, .group_three_select_n,
   .individual_output_lines, .rs485_driver_enable, .high_current_channels,
   .dma_request_zero_n, .cpuDmaReqZero_n, .expansion_bus_interrupt_n, .cpuIntOne_n,
   .reserved_interrupt_n, .headerReset_n, .boardReset_n
);
`default_nettype wire

//--- dv/expansion_bus_model.sv
// Expansion board logic answering reads in the three select groups
`timescale 1ns/1ps
`default_nettype none
module expansion_bus_model (
   // Processor side
   input wire logic clk_sys,
   input wire logic ioRd_n,
   input wire logic [3:0] regIndex,
   input wire logic [2:0] selN,
   // Data lines back to the glue
   output logic [7:0] expDataIn
);
   initial expDataIn = 8'h00;
   // Released lines toggle so stale data never looks valid
   always @(posedge clk_sys) begin
      if (!ioRd_n && selN != 3'h7) begin
         expDataIn <= {(!selN[0]) ? 4'h5 : (!selN[1]) ? 4'h6 : 4'h7, regIndex};
      end else begin
         expDataIn <= ~expDataIn;
      end
   end
endmodule // expansion_bus_model
`default_nettype wire

//--- dv/test_board_io_glue_decoder.sv
// Self-checking bench for the board I/O glue
`timescale 1ns/1ps
`default_nettype none
`include "board_io_regs.vh"
module test_board_io_glue_decoder;
   logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ioRd_n, ioWr_n;
   logic [7:0] wb_adr_i, ioWrData, ioRdData, expDataIn, expDataOut, expDataOe, parallel_output_lines;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [15:0] ioAddr;
   logic [11:0] digital_input_lines;
   logic [5:0] individual_output_lines;
   logic [6:0] high_current_channels;
   logic group_one_select_n, group_two_select_n, group_three_select_n, rs485_driver_enable;
   logic eepromClock, eepromClockFromCore, highCurrentDriverEnable, baudTickZero, baudTickOne;
   logic serialRs485Mode, dma_request_zero_n, dma_request_one_n, cpuDmaReqZero_n, cpuDmaReqOne_n;
   logic expansion_bus_interrupt_n, user_interrupt_n, reserved_interrupt_n, cpuIntOne_n;
   logic cpuIntTwo_n, headerReset_n, boardReset_n;
   int bad_count = 0;
   int n_checks = 0;
   localparam logic [7:0] aPout = {`REG_POUT, 2'b00};
   localparam logic [7:0] aIout = {`REG_IOUT, 2'b00};
   localparam logic [7:0] aChan = {`REG_CHANNEL, 2'b00};
   localparam logic [7:0] aCfg = {`REG_CFG, 2'b00};
   board_io_glue_decoder dut (
      .clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .ioAddr, .ioRd_n, .ioWr_n, .ioWrData, .ioRdData,
      .group_one_select_n, .group_two_select_n, .group_three_select_n,
      .digital_input_lines, .parallel_output_lines, .individual_output_lines,
      .rs485_driver_enable, .eepromClock, .eepromClockFromCore, .high_current_channels,
      .highCurrentDriverEnable, .baudTickZero, .baudTickOne, .serialRs485Mode,
      .expDataIn, .expDataOut, .expDataOe, .dma_request_zero_n, .dma_request_one_n,
      .cpuDmaReqZero_n, .cpuDmaReqOne_n, .expansion_bus_interrupt_n, .user_interrupt_n,
      .reserved_interrupt_n, .cpuIntOne_n, .cpuIntTwo_n, .headerReset_n, .boardReset_n
   );
   expansion_bus_model partner (.clk_sys, .ioRd_n, .regIndex(ioAddr[3:0]),
      .selN({group_three_select_n, group_two_select_n, group_one_select_n}), .expDataIn);
   always #5 clk_sys = ~clk_sys;
   // --------
   // Shared tasks
   // --------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
      end
   endtask
   // Wishbone classic cycle; waits two edges after ack so outputs settle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1) begin
         @(posedge clk_sys);
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic ioRead(input logic [15:0] a);
      ioAddr <= a;
      ioRd_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("selects", {29'h0, ~{a[15:4] == 12'h017, a[15:4] == 12'h016, a[15:4] == 12'h015}},
         {29'h0, group_three_select_n, group_two_select_n, group_one_select_n});
      if (a[15:4] >= 12'h015 && a[15:4] <= 12'h017)
         chk("ioRdData", {24'h0, a[7:0]}, {24'h0, ioRdData});
      ioRd_n <= 1'b1;
      @(posedge clk_sys);
      chk("idleSelects", 32'h7, {29'h0, group_three_select_n, group_two_select_n,
         group_one_select_n});
   endtask
   // --------
   // Scenarios
   // --------
   task automatic tInputs;
      wb(1'b0, 8'hFC, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(1'b0, 8'h00, 32'h0);
      chk("din", 32'hA5C, q);
      wb(1'b1, aChan, 32'h001);
      wb(1'b0, aChan, 32'h0);
      chk("chan1", 32'h0, {31'h0, q[8]});
      wb(1'b1, aChan, 32'h10C);
      wb(1'b0, aChan, 32'h0);
      chk("chan12", 32'h1, {31'h0, q[8]});
   endtask
   task automatic tOutputs;
      wb(1'b1, aPout, 32'hA5);
      wb(1'b1, aChan, 32'h008);
      chk("parallel", 32'h25, {24'h0, parallel_output_lines});
      wb(1'b1, aIout, 32'h3F);
      chk("hcOff", 32'h0, {25'h0, high_current_channels});
      chk("individual", 32'h3F, {26'h0, individual_output_lines});
      chk("drvEnableOff", 32'h0, {31'h0, rs485_driver_enable});
      wb(1'b1, aIout, 32'h55);
      chk("hcOn", 32'h55, {25'h0, high_current_channels});
      chk("drvEnable", 32'h1, {31'h0, highCurrentDriverEnable});
      chk("drvEnableOn", 32'h1, {31'h0, rs485_driver_enable});
      wb(1'b1, aCfg, 32'h1);
      wb(1'b1, aChan, 32'h110);
      chk("sclGpo", 32'h1, {31'h0, eepromClock});
      wb(1'b1, aCfg, 32'h0);
      chk("sclCore", 32'h0, {31'h0, eepromClock});
   endtask
   task automatic tSerial;
      int n;
      n = 0;
      wb(1'b1, {`REG_SERIAL, 2'b00}, 32'h108);
      chk("rs485Mode", 32'h1, {31'h0, serialRs485Mode});
      while (baudTickZero !== 1'b1 && n < 3000) begin
         @(posedge clk_sys);
         n++;
      end
      n = 1;
      @(posedge clk_sys);
      while (baudTickZero !== 1'b1 && n < 300) begin
         @(posedge clk_sys);
         n++;
      end
      chk("baudPeriod", `CLK_HZ / (`BAUD_OVERSAMPLE * `BAUD_MAX), n);
      // Port one still at its slowest rate code
      n = 0;
      while (baudTickOne !== 1'b1 && n < 25000) begin
         @(posedge clk_sys);
         n++;
      end
      n = 1;
      @(posedge clk_sys);
      while (baudTickOne !== 1'b1 && n < 25000) begin
         @(posedge clk_sys);
         n++;
      end
      chk("baudPeriodOne", `CLK_HZ / (`BAUD_OVERSAMPLE * `BAUD_MIN), n);
   endtask
   task automatic tBus;
      for (int g = 5; g < 8; g++)
         for (int r = 0; r < 16; r += 5)
            ioRead({8'h01, g[3:0], r[3:0]});
      ioRead(16'h0180);
      wb(1'b0, {`REG_STATUS, 2'b00}, 32'h0);
      chk("selSeen", 32'h7, {29'h0, q[18:16]});
      chk("headerIdle", 32'h1F, {27'h0, q[4:0]});
      wb(1'b1, {`REG_STATUS, 2'b00}, 32'h0);
      wb(1'b0, {`REG_STATUS, 2'b00}, 32'h0);
      chk("selCleared", 32'h0, {29'h0, q[18:16]});
      ioAddr <= 16'h016A;
      ioWrData <= 8'h3C;
      ioWr_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk("wrSelect", 32'h0, {31'h0, group_two_select_n});
      chk("busOut", 32'hFF3C, {16'h0, expDataOe, expDataOut});
      ioWr_n <= 1'b1;
      wb(1'b1, aCfg, 32'h2);
      wb(1'b1, {`REG_XOUT, 2'b00}, 32'h5A);
      wb(1'b1, {`REG_XOE, 2'b00}, 32'hF0);
      chk("gpioOut", 32'hF05A, {16'h0, expDataOe, expDataOut});
   endtask
   task automatic tHeader;
      dma_request_zero_n <= 1'b0;
      dma_request_one_n <= 1'b0;
      expansion_bus_interrupt_n <= 1'b0;
      user_interrupt_n <= 1'b0;
      headerReset_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("headerLines", 32'h0, {27'h0, boardReset_n, cpuDmaReqZero_n, cpuDmaReqOne_n,
         cpuIntOne_n, cpuIntTwo_n});
      headerReset_n <= 1'b1;
      @(posedge clk_sys);
      chk("resetRelease", 32'h1, {31'h0, boardReset_n});
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #600000;
      bad_count++;
      end_sim;
   end
   initial begin
      {clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, eepromClockFromCore} = 6'h00;
      {ioRd_n, ioWr_n, dma_request_zero_n, dma_request_one_n} = 4'hF;
      {expansion_bus_interrupt_n, user_interrupt_n, headerReset_n} = 3'h7;
      {wb_adr_i, wb_dat_i, ioAddr, ioWrData} = 64'h0;
      wb_sel_i = 4'hF;
      digital_input_lines = 12'hA5C;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      chk("reservedIrq", 32'h1, {31'h0, reserved_interrupt_n});
      tInputs();
      tOutputs();
      tSerial();
      tBus();
      tHeader();
      end_sim();
   end
endmodule // test_board_io_glue_decoder
`default_nettype wire
